// >>> rtl/rmf_pkg.sv
// Constants, register map and path modes of the receive rate match FIFO
//Function
//- Match pattern is a software programmed 20-bit value
//- Find control then skip; deletes only once aligned, inserts without sync check
//- Add or drop skips against clock offset
//- Single width: insert four at most, cluster five
//- Single width: delete four at most, keep one
//- Single width: drop the symbol that fills
//- Single width: emit one pad symbol on empty
//- Double width: insert whole skip pairs, unlimited
//- Double width: delete whole skip pairs only
//- Double width: drop whole word that fills
//- Double width: emit pad pair on empty
//- Low latency takes the one-flop bypass path, FIFO unused
//- Low latency bypasses matching, coding bit still sets fabric width
//- Disabled adds FIFO latency, bypassed adds one flop
//- Transmit bit-slip always reported inactive
//- Blocks selectable, deskew never usable
//- Lane width 8/10/16/20, fabric width by coding
//- Byte serializer doubles fabric width, halves clock
`default_nettype none

package rmf_pkg;

    localparam int SYM_W  = 10;                       // One lane symbol
    localparam int WORD_W = 20;                       // Two lanes
    localparam int DEPTH  = 16;                       // FIFO entries
    localparam int IDX_W  = 4;                        // Entry index
    localparam int PTR_W  = 5;                        // Pointer with wrap
    localparam int CTRL_W = 8;                        // Control width
    localparam int PAT_W  = 20;                       // Pattern width
    localparam int CNT_W  = 16;                       // Event counters
    localparam int ADDR_W = 4;                        // Register address
    localparam int DATA_W = 32;                       // Register data

    localparam logic [PTR_W-1:0] LVL_FULL = 5'h0F;    // Last free slot
    localparam logic [PTR_W-1:0] LVL_HI   = 5'h0A;    // Delete threshold
    localparam logic [PTR_W-1:0] LVL_LO   = 5'h06;    // Insert threshold

    localparam logic [2:0] SW_INS_MAX = 3'h4;         // Inserts per cluster
    localparam logic [2:0] SW_DEL_MAX = 3'h4;         // Deletes per cluster
    localparam logic [2:0] SW_CLU_MAX = 3'h5;         // Cluster size cap
    localparam logic [2:0] CNT_ONE    = 3'h1;         // First skip seen

    // Pad code group: K flag in bit 8, byte FE below
    localparam logic [SYM_W-1:0] PAD_SYM = 10'h1FE;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PAT  = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_CNT  = 4'hC;

    // Control field positions
    localparam int CB_EN  = 0;                        // Rate match enable
    localparam int CB_DW  = 1;                        // Double width
    localparam int CB_BYP = 2;                        // Rate match bypass
    localparam int CB_LL  = 3;                        // Low latency
    localparam int CB_SER = 4;                        // Byte serializer
    localparam int CB_ENC = 5;                        // Coded stream
    localparam int CB_LW  = 6;                        // Lane width, 2 bits

    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [PAT_W-1:0]  PAT_RST  = 20'h00000;

    // Lane width codes and bit counts
    localparam logic [1:0] LW_8  = 2'h0;
    localparam logic [1:0] LW_10 = 2'h1;
    localparam logic [1:0] LW_16 = 2'h2;
    localparam logic [7:0] W8    = 8'h08;
    localparam logic [7:0] W10   = 8'h0A;
    localparam logic [7:0] W16   = 8'h10;
    localparam logic [7:0] W20   = 8'h14;

    // Status field positions
    localparam int SB_LVL  = 0;                       // Level, 5 bits
    localparam int SB_FULL = 5;
    localparam int SB_EMP  = 6;
    localparam int SB_RUN  = 7;
    localparam int SB_FAB  = 8;                       // Fabric width, 8 bits
    localparam int SB_SLIP = 16;                      // Tx bit-slip active
    localparam int SB_DSK  = 17;                      // Deskew usable
    localparam int SB_HALF = 18;                      // Fabric clock halved

    // Path through the block
    typedef enum logic [1:0] {
        RMF_OFF,                                      // Disabled: plain FIFO
        RMF_RUN,                                      // Rate matching
        RMF_BYP                                       // Bypassed: one flop
    } rmf_path_t;

endpackage : rmf_pkg

`default_nettype wire

// >>> rtl/rmf_top.sv
// Receive rate match FIFO with skip insert/delete and register port
`default_nettype none

module rmf_top (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire logic [rmf_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [rmf_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [rmf_pkg::DATA_W-1:0]      reg_rdata,
    input  wire logic                            sync_ok,
    input  wire logic                            in_valid,
    input  wire logic [rmf_pkg::WORD_W-1:0]      in_data,
    input  wire logic                            rd_tick,
    output logic                                 out_valid,
    output logic      [rmf_pkg::WORD_W-1:0]      out_data,
    output logic                                 out_pad
);

    // Register file
    logic [rmf_pkg::CTRL_W-1:0] ctrl_r;               // Mode control
    logic [rmf_pkg::PAT_W-1:0]  pat_r;                // Control+skip pattern
    logic [rmf_pkg::CNT_W-1:0]  ins_tot_r;            // Insert events
    logic [rmf_pkg::CNT_W-1:0]  del_tot_r;            // Delete events
    logic [rmf_pkg::DATA_W-1:0] rdata_r;              // Read data stage

    // FIFO storage and pointers
    logic [rmf_pkg::WORD_W-1:0] mem_r [rmf_pkg::DEPTH];
    logic [rmf_pkg::PTR_W-1:0]  wr_ptr_r;
    logic [rmf_pkg::PTR_W-1:0]  rd_ptr_r;

    // Write side cluster tracking
    logic [rmf_pkg::SYM_W-1:0]  wprev_r;              // Last symbol written
    logic                       wclu_r;               // Inside a cluster
    logic [2:0]                 wdel_r;               // Deletes this cluster

    // Read side cluster tracking
    logic [rmf_pkg::SYM_W-1:0]  rprev_r;              // Last symbol sent
    logic                       rclu_r;               // Inside a cluster
    logic                       rskip_r;              // Last output was skip
    logic [2:0]                 rcnt_r;               // Skips sent in cluster
    logic [2:0]                 ins_r;                // Inserts this cluster

    // Output stage
    logic                       out_valid_r;
    logic [rmf_pkg::WORD_W-1:0] out_data_r;
    logic                       out_pad_r;

    // Mode decode
    wire dw     = ctrl_r[rmf_pkg::CB_DW];
    wire ser    = ctrl_r[rmf_pkg::CB_SER];
    wire enc    = ctrl_r[rmf_pkg::CB_ENC];
    wire [1:0] lw = ctrl_r[rmf_pkg::CB_LW +: 2];
    wire [rmf_pkg::SYM_W-1:0] ctl = pat_r[rmf_pkg::SYM_W-1:0];
    wire [rmf_pkg::SYM_W-1:0] skp = pat_r[rmf_pkg::PAT_W-1:rmf_pkg::SYM_W];

    // Low latency or explicit bypass removes the block from the path
    wire byp_sel = ctrl_r[rmf_pkg::CB_BYP] | ctrl_r[rmf_pkg::CB_LL];
    wire run_sel = ctrl_r[rmf_pkg::CB_EN] & enc;
    rmf_pkg::rmf_path_t path;
    assign path = byp_sel ? rmf_pkg::RMF_BYP :
                  run_sel ? rmf_pkg::RMF_RUN : rmf_pkg::RMF_OFF;
    wire run = (path == rmf_pkg::RMF_RUN);
    wire use_fifo = (path != rmf_pkg::RMF_BYP);

    // Fill level; both pointers live on mclk, enables set the two rates
    wire [rmf_pkg::PTR_W-1:0] lvl = wr_ptr_r - rd_ptr_r;
    wire r_empty = (lvl == '0);

    // Write side pattern search on aligned data only
    wire [rmf_pkg::SYM_W-1:0] w_lo = in_data[rmf_pkg::SYM_W-1:0];
    wire [rmf_pkg::SYM_W-1:0] w_hi =
        in_data[rmf_pkg::WORD_W-1:rmf_pkg::SYM_W];
    wire w_look  = run & sync_ok & in_valid;
    wire w_skip  = (w_lo == skp);
    wire w_pair  = w_skip & (w_hi == skp);
    wire w_start = (wprev_r == ctl) & w_skip;
    wire w_cs    = (w_lo == ctl) & (w_hi == skp);
    wire w_startd = (wprev_r == ctl) & w_pair;
    wire w_in_sw = w_skip & (wclu_r | w_start);
    wire w_in_dw = w_pair & (wclu_r | w_startd);

    // Single width: never the opening skip, so one always stays
    wire w_del_sw = w_look & ~dw & w_in_sw & ~w_start &
                    (lvl >= rmf_pkg::LVL_HI) &
                    (wdel_r < rmf_pkg::SW_DEL_MAX);
    // Double width: a whole skip pair at a time, no count limit
    wire w_del_dw = w_look & dw & w_in_dw &
                    (lvl >= rmf_pkg::LVL_HI);
    wire w_del = w_del_sw | w_del_dw;

    // A write into the last slot is dropped whole
    wire w_full = (lvl == rmf_pkg::LVL_FULL);
    wire w_push = in_valid & use_fifo & ~w_del & ~w_full;

    // Next cluster state of the write side
    wire w_clu_nxt = dw ? (w_cs | w_in_dw) : w_in_sw;
    wire [rmf_pkg::SYM_W-1:0] w_last = dw ? w_hi : w_lo;

    // Read side: head word and insert decision
    wire [rmf_pkg::WORD_W-1:0] head = mem_r[rd_ptr_r[rmf_pkg::IDX_W-1:0]];
    wire h_skip = (head[rmf_pkg::SYM_W-1:0] == skp);
    wire h_pair = h_skip & (head[rmf_pkg::WORD_W-1:rmf_pkg::SYM_W] == skp);
    wire r_low  = run & rd_tick & ~r_empty & (lvl <= rmf_pkg::LVL_LO);
    // Insert only at the cluster's end, so its size is known
    wire r_ins_sw = r_low & ~dw & rclu_r & rskip_r & ~h_skip &
                    (ins_r < rmf_pkg::SW_INS_MAX) &
                    (rcnt_r < rmf_pkg::SW_CLU_MAX);
    wire r_ins_dw = r_low & dw & rclu_r & rskip_r & ~h_pair;
    wire r_ins = r_ins_sw | r_ins_dw;
    wire r_pop = rd_tick & use_fifo & ~r_empty & ~r_ins;
    wire r_pad = rd_tick & run & r_empty;

    // Word leaving the FIFO side this cycle
    wire [rmf_pkg::WORD_W-1:0] pad_word = dw ?
        {rmf_pkg::PAD_SYM, rmf_pkg::PAD_SYM} :
        {{rmf_pkg::SYM_W{1'b0}}, rmf_pkg::PAD_SYM};
    wire [rmf_pkg::WORD_W-1:0] o_word =
        r_pad ? pad_word : (r_ins ? out_data_r : head);
    wire o_go = r_pop | r_ins | r_pad;
    wire [rmf_pkg::SYM_W-1:0] o_lo = o_word[rmf_pkg::SYM_W-1:0];
    wire [rmf_pkg::SYM_W-1:0] o_hi =
        o_word[rmf_pkg::WORD_W-1:rmf_pkg::SYM_W];
    wire o_skip  = (o_lo == skp);
    wire o_pair  = o_skip & (o_hi == skp);
    wire o_start = dw ? (((o_lo == ctl) & (o_hi == skp)) |
                         ((rprev_r == ctl) & o_pair)) :
                        ((rprev_r == ctl) & o_skip);
    wire o_clu   = o_start | (rclu_r & (dw ? o_pair : o_skip));
    wire o_sk    = dw ? o_pair : o_skip;

    // Fabric width report from lane width, coding and serializer
    wire [7:0] lane_bits = (lw == rmf_pkg::LW_8)  ? rmf_pkg::W8  :
                           (lw == rmf_pkg::LW_10) ? rmf_pkg::W10 :
                           (lw == rmf_pkg::LW_16) ? rmf_pkg::W16 :
                                                    rmf_pkg::W20;
    wire [7:0] fab_base = enc ? (dw ? rmf_pkg::W16 : rmf_pkg::W8)
                              : lane_bits;
    wire [7:0] fab_bits = ser ? {fab_base[6:0], 1'b0} : fab_base;

    // Status word; bit-slip and deskew read as permanently off
    logic [rmf_pkg::DATA_W-1:0] stat_w;
    always_comb begin
        stat_w = '0;
        stat_w[rmf_pkg::SB_LVL +: rmf_pkg::PTR_W] = lvl;
        stat_w[rmf_pkg::SB_FULL] = w_full;
        stat_w[rmf_pkg::SB_EMP]  = r_empty;
        stat_w[rmf_pkg::SB_RUN]  = run;
        stat_w[rmf_pkg::SB_FAB +: 8] = fab_bits;
        stat_w[rmf_pkg::SB_SLIP] = 1'b0;
        stat_w[rmf_pkg::SB_DSK]  = 1'b0;
        stat_w[rmf_pkg::SB_HALF] = ser;
    end

    // Register decode and read mux
    wire sel_ctrl = (reg_addr == rmf_pkg::OFF_CTRL);
    wire sel_pat  = (reg_addr == rmf_pkg::OFF_PAT);
    wire sel_stat = (reg_addr == rmf_pkg::OFF_STAT);
    wire sel_cnt  = (reg_addr == rmf_pkg::OFF_CNT);
    wire [rmf_pkg::DATA_W-1:0] rd_mux =
        sel_ctrl ? {{(rmf_pkg::DATA_W-rmf_pkg::CTRL_W){1'b0}}, ctrl_r} :
        sel_pat  ? {{(rmf_pkg::DATA_W-rmf_pkg::PAT_W){1'b0}}, pat_r} :
        sel_stat ? stat_w :
        sel_cnt  ? {del_tot_r, ins_tot_r} : '0;
    wire cnt_clr = reg_wr & sel_cnt;

    // Control and pattern registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= rmf_pkg::CTRL_RST;
            pat_r  <= rmf_pkg::PAT_RST;
        end else if (reg_wr) begin
            if (sel_ctrl) begin
                ctrl_r <= reg_wdata[rmf_pkg::CTRL_W-1:0];
            end
            if (sel_pat) begin
                pat_r <= reg_wdata[rmf_pkg::PAT_W-1:0];
            end
        end
    end

    // Read data appears the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : '0;
        end
    end

    // Event counters; an event in the clearing cycle still counts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ins_tot_r <= '0;
            del_tot_r <= '0;
        end else begin
            if (cnt_clr) begin
                ins_tot_r <= rmf_pkg::CNT_W'(r_ins);
                del_tot_r <= rmf_pkg::CNT_W'(w_del);
            end else begin
                if (r_ins && ins_tot_r != '1) begin
                    ins_tot_r <= ins_tot_r + 1'b1;
                end
                if (w_del && del_tot_r != '1) begin
                    del_tot_r <= del_tot_r + 1'b1;
                end
            end
        end
    end

    // FIFO storage, no reset needed on the data
    always_ff @(posedge mclk) begin
        if (w_push) begin
            mem_r[wr_ptr_r[rmf_pkg::IDX_W-1:0]] <= in_data;
        end
    end

    // Pointers; a bypass empties the FIFO so a later return starts clean
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (!use_fifo) begin
            rd_ptr_r <= wr_ptr_r;
        end else begin
            if (w_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (r_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // Write side cluster state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wprev_r <= '0;
            wclu_r  <= 1'b0;
            wdel_r  <= '0;
        end else if (w_look) begin
            wprev_r <= w_last;
            wclu_r  <= w_clu_nxt;
            if (w_start || w_startd || w_cs || !w_clu_nxt) begin
                wdel_r <= '0;
            end else if (w_del_sw) begin
                wdel_r <= wdel_r + 1'b1;
            end
        end
    end

    // Read side cluster state, fed by every word sent
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rprev_r <= '0;
            rclu_r  <= 1'b0;
            rskip_r <= 1'b0;
            rcnt_r  <= '0;
            ins_r   <= '0;
        end else if (o_go) begin
            rprev_r <= dw ? o_hi : o_lo;
            rclu_r  <= o_clu;
            rskip_r <= o_sk;
            if (o_start) begin
                rcnt_r <= rmf_pkg::CNT_ONE;
                ins_r  <= '0;
            end else if (o_clu && rcnt_r != '1) begin
                rcnt_r <= rcnt_r + 1'b1;
            end
            if (r_ins_sw) begin
                ins_r <= ins_r + 1'b1;
            end
        end
    end

    // Output stage: bypass is the single flop, else the FIFO side
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
            out_pad_r   <= 1'b0;
        end else begin
            case (path)
                rmf_pkg::RMF_BYP: begin
                    out_valid_r <= in_valid;
                    out_data_r  <= in_data;
                    out_pad_r   <= 1'b0;
                end
                rmf_pkg::RMF_OFF, rmf_pkg::RMF_RUN: begin
                    out_valid_r <= o_go;
                    out_pad_r   <= r_pad;
                    if (o_go) begin
                        out_data_r <= o_word;
                    end
                end
                default: begin
                    out_valid_r <= 1'b0;
                    out_pad_r   <= 1'b0;
                end
            endcase
        end
    end

    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;
    assign out_pad   = out_pad_r;
    assign reg_rdata = rdata_r;

    // Checks on the datapath
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_level_bound: assert property (lvl <= rmf_pkg::LVL_FULL)
        else $error("fill level beyond last slot");
    chk_full_drop: assert property (
        in_valid && use_fifo && w_full && !w_del
        |=> wr_ptr_r == $past(wr_ptr_r))
        else $error("word written while full");
    chk_pad_single: assert property (
        r_pad && !dw |=> out_pad_r && out_valid_r &&
        out_data_r[rmf_pkg::SYM_W-1:0] == rmf_pkg::PAD_SYM)
        else $error("single width pad missing");
    chk_pad_double: assert property (
        r_pad && dw |=> out_pad_r &&
        out_data_r == {rmf_pkg::PAD_SYM, rmf_pkg::PAD_SYM})
        else $error("double width pad pair missing");
    chk_del_keep: assert property (
        w_del_sw |-> wclu_r && !w_start && wdel_r < rmf_pkg::SW_DEL_MAX)
        else $error("single width delete out of limits");
    chk_ins_cap: assert property (
        r_ins_sw |-> ins_r < rmf_pkg::SW_INS_MAX &&
        rcnt_r < rmf_pkg::SW_CLU_MAX)
        else $error("single width insert out of limits");
    chk_pair_del: assert property (
        w_del_dw |-> in_data == {skp, skp} && !dw == 1'b0)
        else $error("double width delete not a skip pair");
    chk_ins_repeat: assert property (
        r_ins |=> out_valid_r && out_data_r == $past(out_data_r) &&
        rd_ptr_r == $past(rd_ptr_r))
        else $error("insert did not repeat the skip");
    chk_bypass_flow: assert property (
        path == rmf_pkg::RMF_BYP |=> out_valid_r == $past(in_valid) &&
        out_data_r == $past(in_data))
        else $error("bypass adds latency or alters data");
    chk_stat_fixed: assert property (
        reg_rd && sel_stat |=> reg_rdata[rmf_pkg::SB_SLIP] == 1'b0 &&
        reg_rdata[rmf_pkg::SB_DSK] == 1'b0)
        else $error("bit-slip or deskew reported active");
    // Disabled path keeps the FIFO plain: no skip edits, no pad
    chk_off_plain: assert property (
        path == rmf_pkg::RMF_OFF |-> !r_ins && !w_del && !r_pad)
        else $error("disabled path edited the stream");
    // Deletes only act on a skip seen while the aligner holds sync
    chk_sync_gate: assert property (
        w_del |-> sync_ok && in_valid &&
        in_data[rmf_pkg::SYM_W-1:0] == skp)
        else $error("delete without word sync or skip");
    // A counter clear leaves at most the event of that cycle
    chk_cnt_clear: assert property (
        cnt_clr |=> ins_tot_r <= rmf_pkg::CNT_W'(rmf_pkg::CNT_ONE) &&
        del_tot_r <= rmf_pkg::CNT_W'(rmf_pkg::CNT_ONE))
        else $error("event counter not cleared");

    // Main scenarios reached by the bench
    cov_pad:     cover property (r_pad);
    cov_del_sw:  cover property (w_del_sw);
    cov_ins_dw:  cover property (r_ins_dw);
    cov_full:    cover property (in_valid && use_fifo && w_full);
    cov_ins_sw:  cover property (r_ins_sw);

endmodule : rmf_top

`default_nettype wire

// >>> verif/rmf_src.sv
// Word aligner model that feeds aligned words into the FIFO
`default_nettype none

module rmf_src (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       send,
    input  wire logic                       lost,
    input  wire logic [rmf_pkg::WORD_W-1:0] word,
    output var  logic                       sync_ok,
    output var  logic                       in_valid,
    output var  logic [rmf_pkg::WORD_W-1:0] in_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // Boundary held after reset unless dropped; one word per request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ok  <= 1'b0;
            in_valid <= 1'b0;
            in_data  <= 20'h00000;
        end else begin
            sync_ok  <= ~lost;
            in_valid <= send;
            // Idle data toggles so stale words never look valid
            in_data  <= send ? word : ~in_data;
        end
    end
endmodule : rmf_src

`default_nettype wire

// >>> verif/test_custom_pcs_rate_match_fifo.sv
// Self-checking bench of the receive rate match FIFO
`default_nettype none

module test_custom_pcs_rate_match_fifo;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] CTL = 10'h37C;      // Control symbol
    localparam logic [9:0] SKP = 10'h3E8;      // Skip symbol
    logic        mclk, rst_n, reg_wr, reg_rd, rd_tick, send, lost;
    logic        sync_ok, in_valid, out_valid, out_pad;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [19:0] word, in_data, out_data, w, sk, op, pd;
    logic [15:0] seed = 16'h0022;              // Stream start
    logic [7:0]  lw[4] = '{8'h08, 8'h0A, 8'h10, 8'h14};
    logic [19:0] ex[$];                        // Expected output words
    int          fail_count = 0;
    int          comparisons = 0;

    rmf_src i_src (.mclk(mclk), .rst_n(rst_n), .send(send), .word(word),
        .lost(lost), .sync_ok(sync_ok), .in_valid(in_valid),
        .in_data(in_data));
    rmf_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sync_ok(sync_ok), .in_valid(in_valid),
        .in_data(in_data), .rd_tick(rd_tick), .out_valid(out_valid),
        .out_data(out_data), .out_pad(out_pad));

    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Shift register stream; bit 9 of each lane cleared to miss symbols
    function logic [19:0] rw();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return {seed[3:0], seed} & 20'h7FDFF;
    endfunction : rw
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task complete_run();
        $display("Checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr
    task rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask : rd
    task put(input logic [19:0] d);
        @(posedge mclk);
        send <= 1'b1;
        word <= d;
        @(posedge mclk);
        send <= 1'b0;
    endtask : put
    task pull(input logic [19:0] e, input logic p);
        @(posedge mclk);
        rd_tick <= 1'b1;
        @(posedge mclk);
        rd_tick <= 1'b0;
        #1 chk("out_valid", 1'b1, out_valid);
        chk("out_data", e, out_data);
        chk("out_pad", p, out_pad);
    endtask : pull
    // Read out every queued word, then optionally one pad word
    task drain(input logic pad_end);
        while (ex.size() > 0) pull(ex.pop_front(), 1'b0);
        if (pad_end) pull(pd, 1'b1);
    endtask : drain
    task rst();
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
    endtask : rst

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        {lost, reg_wr, reg_rd, rd_tick, send, reg_addr} = 9'h000;
        reg_wdata = 32'h00000000;
        word = 20'h00000;
        rst_n = 1'b0;
        rst();
        rd("ctrl", rmf_pkg::OFF_CTRL, 32'h00000000);
        rd("pat", rmf_pkg::OFF_PAT, 32'h00000000);
        rd("unmapped", 4'h2, 32'h00000000);
        wr(rmf_pkg::OFF_STAT, 32'hFFFFFFFF);
        // Raw lane widths; status must ignore the write above
        for (int i = 0; i < 4; i++) begin
            wr(rmf_pkg::OFF_CTRL, i << 6);
            rd("stat", rmf_pkg::OFF_STAT, {lw[i], 8'h40});
        end
        wr(rmf_pkg::OFF_CTRL, 32'h000000F3);
        rd("stat", rmf_pkg::OFF_STAT, 32'h000420C0);
        // Bypass and low latency override an enabled match path
        for (int k = 0; k < 2; k++) begin
            wr(rmf_pkg::OFF_CTRL, k ? 32'h00000029 : 32'h00000025);
            w = rw();
            put(w);
            @(posedge mclk);
            #1 chk("byp_data", w, out_data);
            chk("byp_valid", 1'b1, out_valid);
        end
        for (int m = 0; m < 2; m++) begin
            sk = m ? {SKP, SKP} : {10'h000, SKP};
            op = m ? {SKP, CTL} : {10'h000, CTL};
            pd = m ? {2{rmf_pkg::PAD_SYM}} : {10'h000, rmf_pkg::PAD_SYM};
            wr(rmf_pkg::OFF_CTRL, m ? 32'h000000E3 : 32'h00000061);
            wr(rmf_pkg::OFF_PAT, {SKP, CTL});
            // Sixteen writes with no reads: the last one is dropped
            for (int i = 0; i < 16; i++) begin
                w = rw();
                put(w);
                if (i < 15) ex.push_back(w);
            end
            rd("stat", rmf_pkg::OFF_STAT,
               {m ? 8'h10 : 8'h08, 8'hAF});
            drain(1'b1);
            // Cluster behind a deep FIFO loses skips
            wr(rmf_pkg::OFF_CNT, 32'h00000000);
            for (int i = 0; i < 12; i++) begin
                w = rw();
                put(w);
                ex.push_back(w);
            end
            put(op);
            ex.push_back(op);
            repeat (6) put(sk);
            if (m == 0) ex = {ex, sk, sk};
            rd("deletes", rmf_pkg::OFF_CNT,
               m ? 32'h60000 : 32'h40000);
            drain(1'b1);
            // Shorter deep cluster of three skips without word sync passes untouched
            wr(rmf_pkg::OFF_CNT, 32'h00000000);
            lost <= 1'b1;
            for (int i = 0; i < 15; i++) begin
                w = (i < 11) ? rw() : ((i == 11) ? op : sk);
                put(w);
                ex.push_back(w);
            end
            rd("sync_deletes", rmf_pkg::OFF_CNT, 32'h00000000);
            drain(1'b1);
            lost <= 1'b0;
            // Shallow FIFO after a skip repeats skips
            wr(rmf_pkg::OFF_CNT, 32'h00000000);
            w = rw();
            put(op);
            put(sk);
            put(w);
            ex = {op, sk, sk, sk, sk, sk};
            if (m) ex = {ex, sk, sk};
            else ex.push_back(w);
            drain(m == 0);
            rd("inserts", rmf_pkg::OFF_CNT, m ? 32'h6 : 32'h4);
            rst();
        end
        complete_run();
    end
endmodule : test_custom_pcs_rate_match_fifo

`default_nettype wire
